// File: rtl/omd_params.svh
`ifndef OMD_PARAMS_SVH
`define OMD_PARAMS_SVH
// Addressing-mode codes
`define OMD_CODE_REG_LAST 5'h07
`define OMD_CODE_RREL_LAST 5'h0F
`define OMD_CODE_MREL_FP 5'h10
`define OMD_CODE_MREL_SP 5'h11
`define OMD_CODE_MREL_SB 5'h12
`define OMD_CODE_RESERVED 5'h13
`define OMD_CODE_IMM 5'h14
`define OMD_CODE_ABS 5'h15
`define OMD_CODE_EXT 5'h16
`define OMD_CODE_TOS 5'h17
`define OMD_CODE_MSP_FP 5'h18
`define OMD_CODE_MSP_SP 5'h19
`define OMD_CODE_MSP_SB 5'h1A
`define OMD_CODE_MSP_PC 5'h1B
`define OMD_CODE_INDEX_FIRST 5'h1C
// Field positions in the 24-bit basic instruction
`define OMD_GEN_A_LSB 19
`define OMD_GEN_B_LSB 14
`define OMD_QUICK_LSB 7
`define OMD_COND_LSB 4
`define OMD_REG_LSB 11
`define OMD_AREG_LSB 15
// Index byte layout
`define OMD_IDX_MODE_LSB 3
// Offset length encodings in the top bits
`define OMD_OFS_RESERVED_TOP 8'hE0
// Reset value and word size in bytes
`define OMD_RESET_WORD 32'h0000_0000
`define OMD_WORD_BYTES 3'h4
`endif

// File: rtl/omd_pkg.sv
`default_nettype none
package omd_pkg;
  typedef enum logic [3:0] {
    OMD_REGISTER, OMD_REG_RELATIVE, OMD_MEM_RELATIVE, OMD_RESERVED,
    OMD_IMMEDIATE, OMD_ABSOLUTE, OMD_EXTERNAL, OMD_TOP_OF_STACK,
    OMD_MEM_SPACE
  } omd_class_t;
  typedef enum {OMD_ST_IDLE, OMD_ST_PTR} omd_state_t;
  typedef struct packed {
    omd_class_t mode_class;
    logic [2:0] reg_num;
    logic use_register;
    logic use_queue;
    logic ea_valid;
    logic [31:0] ea;
    logic push;
    logic pop;
    logic illegal;
  } omd_result_t;
  typedef struct packed {
    logic [3:0] quick;
    logic [3:0] cond;
    logic [2:0] reg_sel;
    logic [3:0] areg_sel;
    logic [7:0] implied_imm;
  } omd_fields_t;
endpackage
`default_nettype wire

// File: rtl/omd_decoder.sv
// What this block does
// [RULE1] Codes 0-7 take the operand from general register low bits, no address.
// [RULE2] Codes 8-15 add first offset to the selected general register.
// [RULE3] Memory relative reads pointer at first offset plus base, adds second offset.
// [RULE4] Stack pointer references pick user or interrupt pointer by status bit.
// [RULE5] The code after memory relative is reserved and flagged, never decoded.
// [RULE6] Immediate takes the operand from the instruction queue, no address.
// [RULE7] Absolute address equals the first offset alone.
// [RULE8] External reads pointer from link table entry first offset, adds second offset.
// [RULE9] Top of stack pushes on write, pops on read, current stack.
// [RULE10] Each mode-selectable field accepts every defined mode.
// [RULE11] Quick constant is a 4-bit field in the basic instruction.
// [RULE12] Implied constant is an 8-bit byte after all mode extensions.
// [RULE13] Offsets of 8, 16 or 32 bits are all legal.
// [RULE14] Condition is a 4-bit field in the basic instruction.
// [RULE15] Register field selects any of eight general registers.
// [RULE16] Processor-register field selects address, debug, status or configuration.
// [RULE17] Mode fields are 5 bits, at most two per instruction.
// [RULE18] Immediate is illegal for an operand that is written.
// [RULE19] Scaled index adds register times 1, 2, 4 or 8 to base address.
`include "omd_params.svh"
`default_nettype none
module omd_decoder
  import omd_pkg::*;
#(
  parameter int NUM_REGS = 8
) (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic start_in,
  input wire logic [23:0] basic_instr_in,
  input wire logic field_sel_in,
  input wire logic operand_written_in,
  input wire logic [7:0] index_byte_in,
  input wire logic [31:0] first_offset_in,
  input wire logic [31:0] second_offset_in,
  input wire logic [7:0] trailing_byte_in,
  input wire logic [NUM_REGS*32-1:0] general_registers_in,
  input wire logic [31:0] frame_base_in,
  input wire logic [31:0] static_base_in,
  input wire logic [31:0] program_counter_in,
  input wire logic [31:0] link_table_base_in,
  input wire logic [31:0] user_stack_pointer_in,
  input wire logic [31:0] interrupt_stack_pointer_in,
  input wire logic stack_select_in,
  input wire logic ptr_valid_in,
  input wire logic [31:0] ptr_data_in,
  output var omd_result_t result_out,
  output var omd_fields_t fields_out,
  output logic [1:0] first_len_out,
  output logic [1:0] second_len_out,
  output logic done_out,
  output logic busy_out,
  output logic ptr_req_out,
  output logic [31:0] ptr_addr_out
);
  if (NUM_REGS != 8) begin : g_chk
    $error("omd_decoder serves exactly eight general registers");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Offset field decoding, used for both offsets
  // Length code: 0 byte, 1 word, 2 double; 3 marks the reserved top pattern
  function automatic logic [33:0] decode_offset(input logic [31:0] raw);
    logic [33:0] r;
    r = {2'h0, `OMD_RESET_WORD};
    if (!raw[31]) begin
      r = {2'h0, {25{raw[30]}}, raw[30:24]};
    end else if (!raw[30]) begin
      r = {2'h1, {18{raw[29]}}, raw[29:16]};
    end else if (raw[31:24] == `OMD_OFS_RESERVED_TOP) begin
      r = {2'h3, `OMD_RESET_WORD};
    end else begin
      r = {2'h2, {2{raw[29]}}, raw[29:0]};
    end
    return r;
  endfunction

  logic [33:0] ofs1, ofs2;
  logic [31:0] first_offset, second_offset;
  logic [4:0] gen, base_mode;
  logic indexed;
  logic [31:0] cur_sp, idx_add, base_reg;
  logic [2:0] idx_reg;
  // [RULE13] all lengths legal
  assign ofs1 = decode_offset(first_offset_in);
  assign ofs2 = decode_offset(second_offset_in);
  assign first_offset = ofs1[31:0];
  assign second_offset = ofs2[31:0];
  // [RULE17] two 5-bit fields
  assign gen = field_sel_in ? basic_instr_in[`OMD_GEN_B_LSB +: 5]
                            : basic_instr_in[`OMD_GEN_A_LSB +: 5];
  // [RULE19] index byte gives base mode
  assign indexed = gen >= `OMD_CODE_INDEX_FIRST;
  assign base_mode = indexed ? index_byte_in[`OMD_IDX_MODE_LSB +: 5] : gen;
  assign idx_reg = index_byte_in[2:0];
  // [RULE19] scale 1, 2, 4 or 8
  assign idx_add = indexed ? (general_registers_in[idx_reg*32 +: 32] << gen[1:0]) : 32'h0;
  // [RULE4] current stack pointer
  assign cur_sp = stack_select_in ? user_stack_pointer_in : interrupt_stack_pointer_in;
  assign base_reg = general_registers_in[base_mode[2:0]*32 +: 32];

  ////////////////////////////////////////////////////////////////////////////
  // Combinational classification of the selected mode field
  omd_result_t next_result;
  logic need_ptr;
  logic uses_ofs;
  logic [31:0] next_ptr_addr;
  always_comb begin
    next_result = '0;
    next_result.mode_class = OMD_RESERVED;
    next_result.reg_num = base_mode[2:0];
    need_ptr = 1'b0;
    uses_ofs = 1'b0;
    next_ptr_addr = `OMD_RESET_WORD;
    // [RULE10] every defined mode accepted
    if (base_mode <= `OMD_CODE_REG_LAST) begin
      // [RULE1] register operand
      next_result.mode_class = OMD_REGISTER;
      next_result.use_register = 1'b1;
    end else if (base_mode <= `OMD_CODE_RREL_LAST) begin
      // [RULE2] register relative
      next_result.mode_class = OMD_REG_RELATIVE;
      uses_ofs = 1'b1;
      next_result.ea_valid = 1'b1;
      next_result.ea = base_reg + first_offset + idx_add;
    end else begin
      case (base_mode)
        `OMD_CODE_MREL_FP, `OMD_CODE_MREL_SP, `OMD_CODE_MREL_SB: begin
          // [RULE3] pointer fetch at base plus first offset
          next_result.mode_class = OMD_MEM_RELATIVE;
          uses_ofs = 1'b1;
          need_ptr = 1'b1;
          next_ptr_addr = first_offset + (base_mode == `OMD_CODE_MREL_FP ? frame_base_in :
                          base_mode == `OMD_CODE_MREL_SP ? cur_sp : static_base_in);
        end
        `OMD_CODE_IMM: begin
          // [RULE6] operand from queue
          next_result.mode_class = OMD_IMMEDIATE;
          next_result.use_queue = 1'b1;
          // [RULE18] written immediate illegal
          next_result.illegal = operand_written_in | indexed;
        end
        `OMD_CODE_ABS: begin
          // [RULE7] offset alone
          next_result.mode_class = OMD_ABSOLUTE;
          uses_ofs = 1'b1;
          next_result.ea_valid = 1'b1;
          next_result.ea = first_offset + idx_add;
        end
        `OMD_CODE_EXT: begin
          // [RULE8] link table entry fetch
          next_result.mode_class = OMD_EXTERNAL;
          uses_ofs = 1'b1;
          need_ptr = 1'b1;
          next_ptr_addr = link_table_base_in + (first_offset << 2);
        end
        `OMD_CODE_TOS: begin
          // [RULE9] push on write, pop on read
          next_result.mode_class = OMD_TOP_OF_STACK;
          next_result.ea_valid = 1'b1;
          next_result.ea = (operand_written_in ? cur_sp - 32'h4 : cur_sp) + idx_add;
          next_result.push = operand_written_in;
          next_result.pop = !operand_written_in;
        end
        `OMD_CODE_MSP_FP, `OMD_CODE_MSP_SP, `OMD_CODE_MSP_SB, `OMD_CODE_MSP_PC: begin
          next_result.mode_class = OMD_MEM_SPACE;
          uses_ofs = 1'b1;
          next_result.ea_valid = 1'b1;
          next_result.ea = first_offset + idx_add + (base_mode == `OMD_CODE_MSP_FP ? frame_base_in :
                           base_mode == `OMD_CODE_MSP_SP ? cur_sp :
                           base_mode == `OMD_CODE_MSP_SB ? static_base_in : program_counter_in);
        end
        default: begin
          // [RULE5] reserved code flagged; nested index also illegal
          next_result.mode_class = OMD_RESERVED;
          next_result.illegal = 1'b1;
        end
      endcase
    end
    // Only a mode with an offset may trip on it: bytes after a register operand are unrelated
    if (uses_ofs && ofs1[33:32] == 2'h3) begin
      next_result.illegal = 1'b1; // Reserved offset pattern
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: pointer modes wait for the memory read of the pointer
  omd_state_t state;
  logic [31:0] held_add;
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      state <= OMD_ST_IDLE;
      result_out <= '0;
      done_out <= 1'b0;
      busy_out <= 1'b0;
      ptr_req_out <= 1'b0;
      ptr_addr_out <= `OMD_RESET_WORD;
      held_add <= `OMD_RESET_WORD;
    end else begin
      done_out <= 1'b0;
      case (state)
        OMD_ST_IDLE: begin
          if (start_in && need_ptr && !next_result.illegal) begin
            state <= OMD_ST_PTR;
            busy_out <= 1'b1;
            ptr_req_out <= 1'b1;
            ptr_addr_out <= next_ptr_addr;
            held_add <= second_offset + idx_add;
            result_out <= next_result;
          end else if (start_in) begin
            result_out <= next_result;
            done_out <= 1'b1;
          end
        end
        OMD_ST_PTR: begin
          // [RULE3] second offset added to pointer
          if (ptr_valid_in) begin
            state <= OMD_ST_IDLE;
            busy_out <= 1'b0;
            ptr_req_out <= 1'b0;
            result_out.ea <= ptr_data_in + held_add;
            result_out.ea_valid <= 1'b1;
            done_out <= 1'b1;
          end
        end
        default: state <= OMD_ST_IDLE;
      endcase
    end
  end

  // Field extraction captured with each decode; a stale value is harmless
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      fields_out <= '0;
      first_len_out <= 2'h0;
      second_len_out <= 2'h0;
    end else if (start_in && state == OMD_ST_IDLE) begin
      // [RULE11] quick constant
      fields_out.quick <= basic_instr_in[`OMD_QUICK_LSB +: 4];
      // [RULE14] condition field
      fields_out.cond <= basic_instr_in[`OMD_COND_LSB +: 4];
      // [RULE15] general register select
      fields_out.reg_sel <= basic_instr_in[`OMD_REG_LSB +: 3];
      // [RULE16] processor register select
      fields_out.areg_sel <= basic_instr_in[`OMD_AREG_LSB +: 4];
      // [RULE12] trailing implied byte
      fields_out.implied_imm <= trailing_byte_in;
      first_len_out <= ofs1[33:32];
      second_len_out <= ofs2[33:32];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  reg_no_addr_a: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RULE1]
    start_in && state == OMD_ST_IDLE && base_mode <= `OMD_CODE_REG_LAST
    |=> done_out && result_out.use_register && !result_out.ea_valid)
    else $error("register mode produced an address");
  rel_ea_sum_a: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RULE2]
    start_in && state == OMD_ST_IDLE && !indexed && gen[4:3] == 2'h1
    |=> result_out.ea == $past(base_reg) + $past(first_offset))
    else $error("register relative address wrong");
  ptr_done_a: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RULE3]
    state == OMD_ST_PTR && ptr_valid_in
    |=> done_out && result_out.ea == $past(ptr_data_in) + $past(held_add))
    else $error("pointer mode address wrong");
  reserved_flag_a: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RULE5]
    start_in && state == OMD_ST_IDLE && base_mode == `OMD_CODE_RESERVED
    |=> done_out && result_out.illegal && result_out.mode_class == OMD_RESERVED)
    else $error("reserved code not flagged");
  imm_write_a: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RULE18]
    start_in && state == OMD_ST_IDLE && gen == `OMD_CODE_IMM && operand_written_in
    |=> result_out.illegal && !result_out.ea_valid)
    else $error("written immediate accepted");
  abs_ea_a: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RULE7]
    start_in && state == OMD_ST_IDLE && gen == `OMD_CODE_ABS
    |=> result_out.ea == $past(first_offset))
    else $error("absolute address wrong");
  tos_dir_a: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RULE9]
    start_in && state == OMD_ST_IDLE && gen == `OMD_CODE_TOS
    |=> result_out.push == $past(operand_written_in) && result_out.pop != result_out.push)
    else $error("stack adjust direction wrong");
  ext_addr_a: assert property (@(posedge clk_sys_in) disable iff (reset_in) // [RULE8]
    start_in && state == OMD_ST_IDLE && gen == `OMD_CODE_EXT && ofs1[33:32] != 2'h3
    |=> ptr_req_out && ptr_addr_out == $past(link_table_base_in) + ($past(first_offset) << 2))
    else $error("link table entry address wrong");
endmodule
`default_nettype wire

// File: tb/operand_mode_decoder_test.sv
`default_nettype none
module operand_mode_decoder_test
  import omd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end

  logic clk_sys_in, reset_in, start_in, field_sel_in, operand_written_in;
  logic [23:0] basic_instr_in;
  logic [7:0] index_byte_in, trailing_byte_in;
  logic [31:0] first_offset_in, second_offset_in, ptr_data_in;
  logic [255:0] general_registers_in;
  logic stack_select_in, ptr_valid_in;
  omd_result_t result_out;
  omd_fields_t fields_out;
  logic [1:0] first_len_out, second_len_out;
  logic done_out, busy_out, ptr_req_out;
  logic [31:0] ptr_addr_out, seen;
  logic busy_seen;
  logic [23:0] instr, sent;
  logic [31:0] ofs1, ofs2;
  logic ssel;
  logic [7:0] idx;
  int fail_count, check_count, i;
  // Bases kept far apart so a wrong base shows up as a wrong address
  localparam logic [31:0] FPV = 32'h0000_2000, SBV = 32'h0000_3000, LTV = 32'h0000_4000;
  localparam logic [31:0] USP = 32'h0000_8000, ISP = 32'h0000_9000, PTR = 32'h0000_6000;
  logic [4:0] pcode [5] = '{5'h10, 5'h11, 5'h11, 5'h12, 5'h16};
  logic psel [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
  logic [31:0] paddr [5] = '{FPV + 32'h5, USP + 32'h5, ISP + 32'h5, SBV + 32'h5, LTV + 32'h14};
  // Byte, negative byte, word and double offset encodings
  logic [31:0] aofs [4] = '{32'h0500_0000, 32'h7F00_0000, 32'h8010_0000, 32'hC000_0100};
  logic [31:0] aea [4] = '{32'h5, 32'hFFFF_FFFF, 32'h10, 32'h100};
  logic [1:0] alen [4] = '{2'h0, 2'h0, 2'h1, 2'h2};

  omd_decoder DUT (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .start_in(start_in),
    .basic_instr_in(basic_instr_in), .field_sel_in(field_sel_in),
    .operand_written_in(operand_written_in), .index_byte_in(index_byte_in),
    .first_offset_in(first_offset_in), .second_offset_in(second_offset_in),
    .trailing_byte_in(trailing_byte_in), .general_registers_in(general_registers_in),
    .frame_base_in(FPV), .static_base_in(SBV), .program_counter_in(32'h0000_5000),
    .link_table_base_in(LTV), .user_stack_pointer_in(USP), .interrupt_stack_pointer_in(ISP),
    .stack_select_in(stack_select_in), .ptr_valid_in(ptr_valid_in), .ptr_data_in(ptr_data_in),
    .result_out(result_out), .fields_out(fields_out), .first_len_out(first_len_out),
    .second_len_out(second_len_out), .done_out(done_out), .busy_out(busy_out),
    .ptr_req_out(ptr_req_out), .ptr_addr_out(ptr_addr_out));

  function automatic logic [31:0] gr(input int n);
    return 32'h1000_0000 + 32'(n) * 32'h100;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // One decode; answers a pointer read with a one-cycle valid pulse
  task automatic decode(input logic [4:0] gen, input logic sel, input logic wr);
    logic got;
    logic pv;
    got = 1'b0;
    sent = instr;
    if (sel) begin
      sent[18:14] = gen;
      sent[23:19] = 5'h14;
    end else begin
      sent[23:19] = gen;
    end
    @(posedge clk_sys_in);
    basic_instr_in <= sent;
    field_sel_in <= sel;
    operand_written_in <= wr;
    first_offset_in <= ofs1;
    second_offset_in <= ofs2;
    stack_select_in <= ssel;
    index_byte_in <= idx;
    start_in <= 1'b1;
    @(posedge clk_sys_in);
    start_in <= 1'b0;
    for (int n = 0; n < 20; n++) begin
      #1;
      if (done_out === 1'b1) return;
      pv = (ptr_req_out === 1'b1) && !got;
      if (pv) begin
        got = 1'b1;
        seen = ptr_addr_out;
        busy_seen = busy_out;
      end
      @(posedge clk_sys_in);
      ptr_valid_in <= pv;
    end
    `CHK(1'b0, 1'b1)
  endtask

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Free-running system clock, 40 ns period
  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end

  // Watchdog, far beyond the hundred or so cycles the sequence needs
  initial begin
    #200000;
    fail_count++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_in = 1'b1;
    start_in = 1'b0;
    field_sel_in = 1'b0;
    operand_written_in = 1'b0;
    basic_instr_in = 24'h0;
    index_byte_in = 8'h0;
    first_offset_in = 32'h0;
    second_offset_in = 32'h0;
    trailing_byte_in = 8'hA7;
    stack_select_in = 1'b0;
    ptr_valid_in = 1'b0;
    ptr_data_in = PTR;
    for (int n = 0; n < 8; n++) general_registers_in[n*32 +: 32] = gr(n);
    instr = 24'h05A5C3;
    ofs1 = 32'h0500_0000;
    ofs2 = 32'h0700_0000;
    ssel = 1'b1;
    idx = 8'h0;
    repeat (6) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    // Register modes, both mode fields
    for (i = 0; i < 16; i++) begin
      decode(5'(i % 8), i[3], 1'b0);
      `CHK(result_out.mode_class, OMD_REGISTER)
      `CHK(result_out.reg_num, 3'(i % 8))
      `CHK(result_out.ea_valid, 1'b0)
    end
    // Register relative
    for (i = 0; i < 8; i++) begin
      decode(5'h08 + 5'(i), 1'b0, 1'b0);
      `CHK(result_out.ea, gr(i) + 32'h5)
    end
    // Absolute over every offset length
    for (i = 0; i < 4; i++) begin
      ofs1 = aofs[i];
      ofs2 = aofs[i];
      decode(5'h15, 1'b0, 1'b0);
      `CHK(result_out.ea, aea[i])
      `CHK(first_len_out, alen[i])
      `CHK(second_len_out, alen[i])
    end
    // Reserved offset pattern flags absolute, but not a register mode that has no offset
    ofs1 = 32'hE000_0000;
    decode(5'h15, 1'b0, 1'b0);
    `CHK({first_len_out, result_out.illegal}, {2'h3, 1'b1})
    decode(5'h03, 1'b0, 1'b0);
    `CHK({result_out.use_register, result_out.illegal}, 2'b10)
    ofs1 = 32'h0500_0000;
    ofs2 = 32'h0700_0000;
    // Pointer modes: frame, both stacks, static, link table
    for (i = 0; i < 5; i++) begin
      ssel = psel[i];
      seen = 32'h0;
      busy_seen = 1'b0;
      decode(pcode[i], 1'b0, 1'b0);
      `CHK(seen, paddr[i])
      `CHK({busy_seen, busy_out}, 2'b10)
      `CHK(result_out.ea, PTR + 32'h7)
    end
    // Reserved code must not decode as a mode
    decode(5'h13, 1'b0, 1'b0);
    `CHK(result_out.mode_class, OMD_RESERVED)
    // Immediate: read from queue, refused when written
    decode(5'h14, 1'b0, 1'b0);
    `CHK({result_out.use_queue, result_out.ea_valid, result_out.illegal}, 3'b100)
    decode(5'h14, 1'b0, 1'b1);
    `CHK(result_out.illegal, 1'b1)
    // Stack top: pop on read, push on write, selected stack
    ssel = 1'b1;
    decode(5'h17, 1'b0, 1'b0);
    `CHK({result_out.pop, result_out.push, result_out.ea}, {2'b10, USP})
    ssel = 1'b0;
    decode(5'h17, 1'b0, 1'b1);
    `CHK({result_out.pop, result_out.push, result_out.ea}, {2'b01, ISP - 32'h4})
    // Basic instruction fields and trailing constant
    `CHK(fields_out.quick, sent[10:7])
    `CHK(fields_out.cond, sent[7:4])
    `CHK(fields_out.reg_sel, sent[13:11])
    `CHK(fields_out.areg_sel, sent[18:15])
    `CHK(fields_out.implied_imm, 8'hA7)
    // Memory space codes: first offset plus frame base or program counter
    decode(5'h18, 1'b0, 1'b0);
    `CHK(result_out.ea, FPV + 32'h5)
    decode(5'h1B, 1'b0, 1'b0);
    `CHK(result_out.ea, 32'h0000_5000 + 32'h5)
    // Scaled index by words over an absolute base
    idx = {5'h15, 3'h2};
    decode(5'h1D, 1'b0, 1'b0);
    `CHK(result_out.ea, 32'h5 + 32'h2 * gr(2))
    print_verdict();
  end
endmodule
`default_nettype wire
